// ### design/smr_pkg.sv
// How it works
// - All-low command with bank zero loads main
// - Main register fields decoded to outputs
// - Recovery code zero forbids auto precharge
// - Sequential burst rotates within groups of four
// - Interleaved burst XORs start with counter
// - Bank one select loads extended one
// - Extended one fields decoded to outputs
// - Bank two select loads extended two
// - Extended two refresh fields decoded
// - Partial refresh range marks retained banks
// - Bank three select loads extended three
// - Calibration field code decoded to modes
package smr_pkg;

  // ----------------------------------------------------------------
  // Register selection and layout
  // ----------------------------------------------------------------
  localparam int ADDR_W = 13;
  localparam logic [1:0] SEL_MAIN = 2'h0;
  localparam logic [1:0] SEL_EXT_ONE = 2'h1;
  localparam logic [1:0] SEL_EXT_TWO = 2'h2;
  localparam logic [1:0] SEL_EXT_THREE = 2'h3;
  localparam logic [12:0] MODE_RESET = 13'h0000;
  localparam int MR_BT = 3;
  localparam int MR_TEST = 7;
  localparam int MR_DLL_RST = 8;
  localparam int E1_DLL_DIS = 0;
  localparam int E1_REDUCED = 1;
  localparam int E1_ODT_LO = 2;
  localparam int E1_ODT_HI = 6;
  localparam int E1_STROBE_DIS = 10;
  localparam int E2_DUTY = 3;
  localparam int E2_HIGH_TEMP = 7;
  localparam logic [2:0] BL_CODE_4 = 3'h2;
  localparam logic [2:0] BL_CODE_8 = 3'h3;
  localparam logic [2:0] WR_NO_AUTOPRE = 3'h0;

  // ----------------------------------------------------------------
  // Timing counts
  // ----------------------------------------------------------------
  localparam logic [7:0] DLL_LOCK_CYCLES = 8'hc8;

  typedef enum {CAL_EXIT, CAL_DRIVE_ONE, CAL_DRIVE_ZERO, CAL_ADJUST,
                CAL_DEFAULT, CAL_RESERVED} smr_cal_t;

  // ----------------------------------------------------------------
  // Field decoders
  // ----------------------------------------------------------------
  function automatic logic [3:0] wr_cycles(input logic [2:0] code);
    wr_cycles = (code == WR_NO_AUTOPRE) ? 4'h0 : {1'b0, code} + 4'h1;
  endfunction : wr_cycles

  // Termination in ohms, zero when off
  function automatic logic [7:0] odt_ohms(input logic [1:0] code);
    case (code)
      2'h1: odt_ohms = 8'h4b;
      2'h2: odt_ohms = 8'h96;
      2'h3: odt_ohms = 8'h32;
      default: odt_ohms = 8'h00;
    endcase
  endfunction : odt_ohms

  // One bit per bank that keeps its data through self refresh
  function automatic logic [3:0] keep_banks(input logic [2:0] code);
    case (code)
      3'h1: keep_banks = 4'h3;
      3'h2: keep_banks = 4'h1;
      3'h4: keep_banks = 4'he;
      3'h5: keep_banks = 4'hc;
      3'h6: keep_banks = 4'h8;
      default: keep_banks = 4'hf;
    endcase
  endfunction : keep_banks

  function automatic smr_cal_t cal_decode(input logic [2:0] code);
    case (code)
      3'h0: cal_decode = CAL_EXIT;
      3'h1: cal_decode = CAL_DRIVE_ONE;
      3'h2: cal_decode = CAL_DRIVE_ZERO;
      3'h4: cal_decode = CAL_ADJUST;
      3'h7: cal_decode = CAL_DEFAULT;
      default: cal_decode = CAL_RESERVED;
    endcase
  endfunction : cal_decode

endpackage : smr_pkg

// ### design/smr_cmd_if.sv
`timescale 1ns/1ps
// Register-write strobes from the pin decoder to the register core
interface smr_cmd_if;
  logic [3:0] wr_sel;
  logic [12:0] opcode;
  modport dec (output wr_sel, output opcode);
  modport core (input wr_sel, input opcode);
endinterface : smr_cmd_if

// ### design/smr_cmd_decode.sv
`timescale 1ns/1ps
module smr_cmd_decode (
  input wire logic clock,
  input wire logic srst,
  input wire logic cke,
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic [1:0] ba,
  input wire logic [12:0] addr,
  smr_cmd_if.dec cmd
);

  logic is_set;

  // ----------------------------------------------------------------
  // Command decode
  // ----------------------------------------------------------------
  // Bank pins pick one of four targets in the same cycle
  always_comb begin
    is_set = cke && !cs_n && !ras_n && !cas_n && !we_n;
    cmd.wr_sel = is_set ? (4'h1 << ba) : 4'h0;
    cmd.opcode = addr;
  end

  property p_one_hot;
    @(posedge clock) disable iff (srst)
      (cmd.wr_sel != 4'h0) |-> $onehot(cmd.wr_sel) && !cs_n && !we_n;
  endproperty
  a_one_hot: assert property (p_one_hot)
    else $error("register select not one-hot");

  property p_sel_bank;
    @(posedge clock) disable iff (srst)
      cmd.wr_sel[2] |-> ba == smr_pkg::SEL_EXT_TWO && cke;
  endproperty
  a_sel_bank: assert property (p_sel_bank)
    else $error("extended two selected by wrong bank");

endmodule : smr_cmd_decode

// ### design/smr_burst_seq.sv
`timescale 1ns/1ps
module smr_burst_seq (
  input wire logic clock,
  input wire logic srst,
  input wire logic start,
  input wire logic [2:0] start_col,
  input wire logic len8,
  input wire logic interleave,
  output logic [2:0] col,
  output logic valid,
  output logic last
);

  typedef enum {SMR_IDLE, SMR_RUN} smr_burst_t;

  smr_burst_t state_ff, nxt_state;
  logic [2:0] beat_ff, nxt_beat;
  logic [2:0] base_ff, nxt_base;
  logic len8_ff, nxt_len8;
  logic ilv_ff, nxt_ilv;
  logic [2:0] col_ff, nxt_col;
  logic last_ff, nxt_last;
  logic valid_ff, nxt_valid;
  logic [2:0] beat_use;
  logic [2:0] top;
  logic [2:0] cur_base;
  logic cur_len8;
  logic cur_ilv;

  // ----------------------------------------------------------------
  // Beat sequencing
  // ----------------------------------------------------------------
  // A new start ends any burst in progress
  always_comb begin
    nxt_state = state_ff;
    nxt_beat = beat_ff;
    nxt_base = base_ff;
    nxt_len8 = len8_ff;
    nxt_ilv = ilv_ff;
    beat_use = 3'h0;
    cur_base = start_col;
    cur_len8 = len8;
    cur_ilv = interleave;
    if (start) begin
      nxt_base = start_col;
      nxt_len8 = len8;
      nxt_ilv = interleave;
    end else if (state_ff == SMR_RUN) begin
      beat_use = beat_ff;
      cur_base = base_ff;
      cur_len8 = len8_ff;
      cur_ilv = ilv_ff;
    end
    top = cur_len8 ? 3'h7 : 3'h3;
    case (state_ff)
      SMR_IDLE: begin
        nxt_beat = 3'h1;
        if (start) nxt_state = SMR_RUN;
      end
      SMR_RUN: begin
        nxt_beat = start ? 3'h1 : beat_ff + 3'h1;
        if (!start && beat_ff == top) nxt_state = SMR_IDLE;
      end
      default: nxt_state = SMR_IDLE;
    endcase
    if (cur_ilv) begin
      nxt_col = cur_base ^ (beat_use & top);
    end else begin
      nxt_col[1:0] = cur_base[1:0] + beat_use[1:0];
      nxt_col[2] = cur_base[2] ^ (cur_len8 & beat_use[2]);
    end
    nxt_last = (start || state_ff == SMR_RUN) && beat_use == top;
    nxt_valid = start || state_ff == SMR_RUN;
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      state_ff <= SMR_IDLE;
      beat_ff <= 3'h0;
      base_ff <= 3'h0;
      len8_ff <= 1'b0;
      ilv_ff <= 1'b0;
      col_ff <= 3'h0;
      last_ff <= 1'b0;
      valid_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      beat_ff <= nxt_beat;
      base_ff <= nxt_base;
      len8_ff <= nxt_len8;
      ilv_ff <= nxt_ilv;
      col_ff <= nxt_col;
      last_ff <= nxt_last;
      valid_ff <= nxt_valid;
    end
  end

  assign col = col_ff;
  assign last = last_ff;
  assign valid = valid_ff;

  property p_seq_second;
    @(posedge clock) disable iff (srst)
      start && !interleave ##1 !start |=>
        col == {$past(start_col[2], 2), $past(start_col[1:0], 2) + 2'h1};
  endproperty
  a_seq_second: assert property (p_seq_second)
    else $error("sequential second beat wrong");

  property p_ilv_len8;
    @(posedge clock) disable iff (srst)
      start && interleave && len8 ##1 !start [*4] |=>
        col == ($past(start_col, 5) ^ 3'h4);
  endproperty
  a_ilv_len8: assert property (p_ilv_len8)
    else $error("interleaved fifth beat wrong");

endmodule : smr_burst_seq

// ### design/smr_top.sv
`timescale 1ns/1ps
module smr_top (
  input wire logic CLOCK,
  input wire logic SRST,
  input wire logic CKE,
  input wire logic CS_N,
  input wire logic RAS_N,
  input wire logic CAS_N,
  input wire logic WE_N,
  input wire logic [1:0] BA,
  input wire logic [12:0] ADDR,
  input wire logic SELF_REFRESH_EXIT,
  input wire logic BURST_START,
  input wire logic [2:0] BURST_START_COL,
  output logic [12:0] OPERATING_MODE,
  output logic [12:0] EXT_MODE_ONE,
  output logic [12:0] EXT_MODE_TWO,
  output logic [12:0] EXT_MODE_THREE,
  output logic [3:0] MODE_VALID,
  output logic BURST_LEN8,
  output logic BURST_LEN_VALID,
  output logic BURST_INTERLEAVE,
  output logic [2:0] CAS_LATENCY,
  output logic TEST_MODE,
  output logic DLL_RESET_PULSE,
  output logic [3:0] WRITE_RECOVERY,
  output logic WRITE_AUTOPRE_OK,
  output logic DLL_ON,
  output logic DLL_READY,
  output logic REDUCED_DRIVE,
  output logic [2:0] ADDITIVE_LATENCY,
  output logic [7:0] ODT_OHMS,
  output logic STROBE_COMPL_DISABLE,
  output logic CAL_DRIVE_HIGH,
  output logic CAL_DRIVE_LOW,
  output logic CAL_ADJUST_MODE,
  output logic CAL_DEFAULT_STATE,
  output logic HIGH_TEMP_SELF_REFRESH,
  output logic DUTY_CYCLE_CORRECTOR_EN,
  output logic [2:0] PARTIAL_ARRAY_SELF_REFRESH,
  output logic [3:0] SELF_REFRESH_KEEP_BANKS,
  output logic [2:0] BURST_COL,
  output logic BURST_VALID,
  output logic BURST_LAST
);

  smr_cmd_if cmd ();

  logic [12:0] mr_ff, nxt_mr;
  logic [12:0] e1_ff, nxt_e1;
  logic [12:0] e2_ff, nxt_e2;
  logic [12:0] e3_ff, nxt_e3;
  logic [3:0] valid_ff, nxt_valid;
  logic dll_on_ff, nxt_dll_on;
  logic [7:0] lock_ff, nxt_lock;
  logic dll_rst_ff, nxt_dll_rst;
  smr_pkg::smr_cal_t cal_ff, nxt_cal;

  // ----------------------------------------------------------------
  // Pin command decode and burst address generator
  // ----------------------------------------------------------------
  smr_cmd_decode u_dec (
    .clock(CLOCK),
    .srst(SRST),
    .cke(CKE),
    .cs_n(CS_N),
    .ras_n(RAS_N),
    .cas_n(CAS_N),
    .we_n(WE_N),
    .ba(BA),
    .addr(ADDR),
    .cmd(cmd.dec)
  );

  smr_burst_seq u_burst (
    .clock(CLOCK),
    .srst(SRST),
    .start(BURST_START),
    .start_col(BURST_START_COL),
    .len8(BURST_LEN8),
    .interleave(BURST_INTERLEAVE),
    .col(BURST_COL),
    .valid(BURST_VALID),
    .last(BURST_LAST)
  );

  // ----------------------------------------------------------------
  // Mode register storage
  // ----------------------------------------------------------------
  // Contents reset to MODE_RESET (all zero); the valid bits let the
  // rest of the chip see which registers were actually written.
  always_comb begin
    nxt_mr = mr_ff;
    nxt_e1 = e1_ff;
    nxt_e2 = e2_ff;
    nxt_e3 = e3_ff;
    nxt_valid = valid_ff | cmd.wr_sel;
    if (cmd.wr_sel[0]) nxt_mr = cmd.opcode;
    if (cmd.wr_sel[1]) nxt_e1 = cmd.opcode;
    if (cmd.wr_sel[2]) nxt_e2 = cmd.opcode;
    if (cmd.wr_sel[3]) nxt_e3 = cmd.opcode;
  end

  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      mr_ff <= smr_pkg::MODE_RESET;
      e1_ff <= smr_pkg::MODE_RESET;
      e2_ff <= smr_pkg::MODE_RESET;
      e3_ff <= smr_pkg::MODE_RESET;
      valid_ff <= 4'h0;
    end else begin
      mr_ff <= nxt_mr;
      e1_ff <= nxt_e1;
      e2_ff <= nxt_e2;
      e3_ff <= nxt_e3;
      valid_ff <= nxt_valid;
    end
  end

  // ----------------------------------------------------------------
  // DLL control and lock wait
  // ----------------------------------------------------------------
  // Every enable and every reset of the DLL restarts the lock wait;
  // leaving self refresh turns the DLL back on by itself.
  always_comb begin
    nxt_dll_on = dll_on_ff;
    nxt_lock = (lock_ff != 8'h00) ? lock_ff - 8'h01 : 8'h00;
    nxt_dll_rst = cmd.wr_sel[0] && cmd.opcode[smr_pkg::MR_DLL_RST];
    if (cmd.wr_sel[1]) begin
      nxt_dll_on = !cmd.opcode[smr_pkg::E1_DLL_DIS];
    end
    if (SELF_REFRESH_EXIT) nxt_dll_on = 1'b1;
    if ((nxt_dll_on && !dll_on_ff) || nxt_dll_rst ||
        (cmd.wr_sel[1] && nxt_dll_on)) begin
      nxt_lock = smr_pkg::DLL_LOCK_CYCLES;
    end
  end

  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      dll_on_ff <= 1'b0;
      lock_ff <= 8'h00;
      dll_rst_ff <= 1'b0;
    end else begin
      dll_on_ff <= nxt_dll_on;
      lock_ff <= nxt_lock;
      dll_rst_ff <= nxt_dll_rst;
    end
  end

  // ----------------------------------------------------------------
  // Driver calibration mode
  // ----------------------------------------------------------------
  always_comb begin
    nxt_cal = cal_ff;
    if (cmd.wr_sel[1]) begin
      nxt_cal = smr_pkg::cal_decode(cmd.opcode[9:7]);
    end
  end

  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      cal_ff <= smr_pkg::CAL_EXIT;
    end else begin
      cal_ff <= nxt_cal;
    end
  end

  // ----------------------------------------------------------------
  // Field outputs
  // ----------------------------------------------------------------
  assign OPERATING_MODE = mr_ff;
  assign EXT_MODE_ONE = e1_ff;
  assign EXT_MODE_TWO = e2_ff;
  assign EXT_MODE_THREE = e3_ff;
  assign MODE_VALID = valid_ff;
  // Only lengths 4 and 8 exist; other codes fall back to 4
  assign BURST_LEN8 = mr_ff[2:0] == smr_pkg::BL_CODE_8;
  assign BURST_LEN_VALID = BURST_LEN8 ||
                           mr_ff[2:0] == smr_pkg::BL_CODE_4;
  assign BURST_INTERLEAVE = mr_ff[smr_pkg::MR_BT];
  assign CAS_LATENCY = mr_ff[6:4];
  assign TEST_MODE = mr_ff[smr_pkg::MR_TEST];
  assign DLL_RESET_PULSE = dll_rst_ff;
  assign WRITE_RECOVERY = smr_pkg::wr_cycles(mr_ff[11:9]);
  assign WRITE_AUTOPRE_OK =
    mr_ff[11:9] != smr_pkg::WR_NO_AUTOPRE;
  assign DLL_ON = dll_on_ff;
  assign DLL_READY = dll_on_ff && lock_ff == 8'h00;
  assign REDUCED_DRIVE = e1_ff[smr_pkg::E1_REDUCED];
  assign ADDITIVE_LATENCY = e1_ff[5:3];
  assign ODT_OHMS = smr_pkg::odt_ohms({e1_ff[smr_pkg::E1_ODT_HI],
                                       e1_ff[smr_pkg::E1_ODT_LO]});
  assign STROBE_COMPL_DISABLE = e1_ff[smr_pkg::E1_STROBE_DIS];
  assign CAL_DRIVE_HIGH = cal_ff == smr_pkg::CAL_DRIVE_ONE;
  assign CAL_DRIVE_LOW = cal_ff == smr_pkg::CAL_DRIVE_ZERO;
  assign CAL_ADJUST_MODE = cal_ff == smr_pkg::CAL_ADJUST;
  assign CAL_DEFAULT_STATE = cal_ff == smr_pkg::CAL_DEFAULT;
  assign HIGH_TEMP_SELF_REFRESH = e2_ff[smr_pkg::E2_HIGH_TEMP];
  assign DUTY_CYCLE_CORRECTOR_EN = e2_ff[smr_pkg::E2_DUTY];
  assign PARTIAL_ARRAY_SELF_REFRESH = e2_ff[2:0];
  assign SELF_REFRESH_KEEP_BANKS = smr_pkg::keep_banks(e2_ff[2:0]);

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_main_capture;
    @(posedge CLOCK) disable iff (SRST)
      CKE && !CS_N && !RAS_N && !CAS_N && !WE_N && BA == 2'h0
        |=> OPERATING_MODE == $past(ADDR) && MODE_VALID[0];
  endproperty
  a_main_capture: assert property (p_main_capture)
    else $error("main register not loaded");

  property p_ext1_capture;
    @(posedge CLOCK) disable iff (SRST)
      CKE && !CS_N && !RAS_N && !CAS_N && !WE_N && BA == 2'h1
        |=> EXT_MODE_ONE == $past(ADDR) && $stable(OPERATING_MODE);
  endproperty
  a_ext1_capture: assert property (p_ext1_capture)
    else $error("extended one not loaded");

  property p_ext3_capture;
    @(posedge CLOCK) disable iff (SRST)
      CKE && !CS_N && !RAS_N && !CAS_N && !WE_N && BA == 2'h3
        |=> EXT_MODE_THREE == $past(ADDR) && $stable(EXT_MODE_TWO);
  endproperty
  a_ext3_capture: assert property (p_ext3_capture)
    else $error("extended three not loaded");

  property p_no_cke_hold;
    @(posedge CLOCK) disable iff (SRST)
      !CKE |=> $stable(OPERATING_MODE) && $stable(EXT_MODE_ONE);
  endproperty
  a_no_cke_hold: assert property (p_no_cke_hold)
    else $error("register changed with clock enable low");

  property p_dll_wait;
    @(posedge CLOCK) disable iff (SRST)
      cmd.wr_sel[1] && !cmd.opcode[0] |=> !DLL_READY [*8];
  endproperty
  a_dll_wait: assert property (p_dll_wait)
    else $error("DLL ready too early");

  property p_dll_lock_len;
    @(posedge CLOCK) disable iff (SRST)
      $rose(DLL_ON) |-> lock_ff == 8'hc8;
  endproperty
  a_dll_lock_len: assert property (p_dll_lock_len)
    else $error("DLL lock wait not 200 cycles");

  property p_wr_autopre;
    @(posedge CLOCK) disable iff (SRST)
      cmd.wr_sel[0] && cmd.opcode[11:9] == 3'h0
        |=> !WRITE_AUTOPRE_OK && WRITE_RECOVERY == 4'h0;
  endproperty
  a_wr_autopre: assert property (p_wr_autopre)
    else $error("auto precharge allowed with recovery code zero");

  property p_cal_adjust;
    @(posedge CLOCK) disable iff (SRST)
      cmd.wr_sel[1] && cmd.opcode[9:7] == 3'h4
        |=> CAL_ADJUST_MODE && !CAL_DEFAULT_STATE;
  endproperty
  a_cal_adjust: assert property (p_cal_adjust)
    else $error("adjust mode not entered");

  property p_ext2_fields;
    @(posedge CLOCK) disable iff (SRST)
      cmd.wr_sel[2] |=> DUTY_CYCLE_CORRECTOR_EN == $past(ADDR[3]) &&
        HIGH_TEMP_SELF_REFRESH == $past(ADDR[7]);
  endproperty
  a_ext2_fields: assert property (p_ext2_fields)
    else $error("extended two fields wrong");

  property p_ext2_capture;
    @(posedge CLOCK) disable iff (SRST)
      CKE && !CS_N && !RAS_N && !CAS_N && !WE_N && BA == 2'h2
        |=> EXT_MODE_TWO == $past(ADDR) && $stable(EXT_MODE_ONE);
  endproperty
  a_ext2_capture: assert property (p_ext2_capture)
    else $error("extended two not loaded");

  property p_keep_banks;
    @(posedge CLOCK) disable iff (SRST)
      cmd.wr_sel[2] && cmd.opcode[2:0] == 3'h2
        |=> SELF_REFRESH_KEEP_BANKS == 4'h1;
  endproperty
  a_keep_banks: assert property (p_keep_banks)
    else $error("retained bank mask wrong");

  property p_cal_exit;
    @(posedge CLOCK) disable iff (SRST)
      cmd.wr_sel[1] && cmd.opcode[9:7] == 3'h0 |=> !CAL_DRIVE_HIGH &&
        !CAL_DRIVE_LOW && !CAL_ADJUST_MODE && !CAL_DEFAULT_STATE;
  endproperty
  a_cal_exit: assert property (p_cal_exit)
    else $error("calibration mode not left");

  property p_dll_off;
    @(posedge CLOCK) disable iff (SRST)
      cmd.wr_sel[1] && cmd.opcode[0] && !SELF_REFRESH_EXIT
        |=> !DLL_ON && !DLL_READY;
  endproperty
  a_dll_off: assert property (p_dll_off)
    else $error("DLL left on after disable");

endmodule : smr_top

// ### sim/smr_ctrl_model.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Controller side of the command pins
// ----------------------------------------------------------------
module smr_ctrl_model (
  input wire logic clock,
  output logic cke,
  output logic cs_n,
  output logic ras_n,
  output logic cas_n,
  output logic we_n,
  output logic [1:0] ba,
  output logic [12:0] addr
);
  logic [12:0] last_addr;

  initial begin
    cke = 1'b0;
    {cs_n, ras_n, cas_n, we_n} = 4'hf;
    ba = 2'h0;
    addr = 13'h0000;
    last_addr = 13'h0000;
  end

  // Held high through calibration, so only the bench lowers it
  task automatic set_cke(input logic v);
    @(posedge clock);
    cke <= v;
  endtask : set_cke

  task automatic issue(input logic [1:0] sel, input logic [12:0] op,
                       input logic [3:0] pins);
    @(posedge clock);
    {cs_n, ras_n, cas_n, we_n} <= pins;
    ba <= sel;
    addr <= op;
    last_addr = op;
  endtask : issue

  // Released pins show the inverse so a stale word never looks valid
  task automatic idle_bus();
    @(posedge clock);
    {cs_n, ras_n, cas_n, we_n} <= 4'hf;
    ba <= ~ba;
    addr <= ~last_addr;
  endtask : idle_bus

  // Callers program all registers after reset with banks idle
  task automatic write_mode(input logic [1:0] sel, input logic [12:0] op);
    logic [12:0] v;
    v = op;
    if (sel == smr_pkg::SEL_EXT_ONE) v[11] = 1'b0;
    if (sel == smr_pkg::SEL_EXT_TWO) v = v & 13'h008f;
    if (sel == smr_pkg::SEL_EXT_THREE) v = 13'h0000;
    issue(sel, v, 4'h0);
    idle_bus();
  endtask : write_mode
endmodule : smr_ctrl_model

// ### sim/tb.sv
`timescale 1ns/1ps
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin n_fail++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (e)); end end
module tb;
  logic CLOCK, SRST, SELF_REFRESH_EXIT, BURST_START;
  logic [2:0] BURST_START_COL;
  logic CKE, CS_N, RAS_N, CAS_N, WE_N;
  logic [1:0] BA;
  logic [12:0] ADDR, OPERATING_MODE, EXT_MODE_ONE, EXT_MODE_TWO;
  logic [12:0] EXT_MODE_THREE;
  logic [3:0] MODE_VALID, WRITE_RECOVERY, SELF_REFRESH_KEEP_BANKS;
  logic BURST_LEN8, BURST_LEN_VALID, BURST_INTERLEAVE, TEST_MODE;
  logic DLL_RESET_PULSE, WRITE_AUTOPRE_OK, DLL_ON, DLL_READY;
  logic REDUCED_DRIVE, STROBE_COMPL_DISABLE, CAL_DRIVE_HIGH;
  logic CAL_DRIVE_LOW, CAL_ADJUST_MODE, CAL_DEFAULT_STATE;
  logic HIGH_TEMP_SELF_REFRESH, DUTY_CYCLE_CORRECTOR_EN;
  logic BURST_VALID, BURST_LAST;
  logic [2:0] CAS_LATENCY, ADDITIVE_LATENCY, PARTIAL_ARRAY_SELF_REFRESH;
  logic [2:0] BURST_COL;
  logic [7:0] ODT_OHMS;
  int n_fail = 0;
  int cmp_count = 0;
  int pulse_cnt = 0;

  smr_top i_dut (.CLOCK, .SRST, .CKE, .CS_N, .RAS_N, .CAS_N, .WE_N, .BA,
    .ADDR, .SELF_REFRESH_EXIT, .BURST_START, .BURST_START_COL,
    .OPERATING_MODE, .EXT_MODE_ONE, .EXT_MODE_TWO, .EXT_MODE_THREE,
    .MODE_VALID, .BURST_LEN8, .BURST_LEN_VALID, .BURST_INTERLEAVE,
    .CAS_LATENCY, .TEST_MODE, .DLL_RESET_PULSE, .WRITE_RECOVERY,
    .WRITE_AUTOPRE_OK, .DLL_ON, .DLL_READY, .REDUCED_DRIVE,
    .ADDITIVE_LATENCY, .ODT_OHMS, .STROBE_COMPL_DISABLE, .CAL_DRIVE_HIGH,
    .CAL_DRIVE_LOW, .CAL_ADJUST_MODE, .CAL_DEFAULT_STATE,
    .HIGH_TEMP_SELF_REFRESH, .DUTY_CYCLE_CORRECTOR_EN,
    .PARTIAL_ARRAY_SELF_REFRESH, .SELF_REFRESH_KEEP_BANKS, .BURST_COL,
    .BURST_VALID, .BURST_LAST);

  smr_ctrl_model ctrl (.clock(CLOCK), .cke(CKE), .cs_n(CS_N),
    .ras_n(RAS_N), .cas_n(CAS_N), .we_n(WE_N), .ba(BA), .addr(ADDR));

  initial begin
    CLOCK = 1'b0;
    forever #25 CLOCK = ~CLOCK;
  end

  always @(posedge CLOCK) if (DLL_RESET_PULSE === 1'b1) pulse_cnt++;

  task automatic give_verdict();
    if (n_fail == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : give_verdict

  // Result checked a cycle after the taking edge, where it has settled
  task automatic wr(input logic [1:0] sel, input logic [12:0] v);
    ctrl.write_mode(sel, v);
    @(posedge CLOCK);
    #1;
  endtask : wr

  task automatic chk_clear();
    `CHK(MODE_VALID, 4'h0)
    `CHK(OPERATING_MODE, 13'h0000)
    `CHK(WRITE_AUTOPRE_OK, 1'b0)
    `CHK(SELF_REFRESH_KEEP_BANKS, 4'hf)
    `CHK(DLL_ON, 1'b0)
  endtask : chk_clear

  task automatic t_main();
    wr(smr_pkg::SEL_MAIN, {1'b0, 3'h5, 1'b1, 1'b0, 3'h5, 1'b0, 3'h3});
    `CHK(OPERATING_MODE, 13'h0b53)
    `CHK({BURST_LEN8, BURST_LEN_VALID, BURST_INTERLEAVE}, 3'h6)
    `CHK({CAS_LATENCY, TEST_MODE}, 4'ha)
    `CHK({WRITE_RECOVERY, WRITE_AUTOPRE_OK}, 5'hd)
    `CHK(pulse_cnt, 1)
    wr(smr_pkg::SEL_MAIN, {1'b0, 3'h0, 1'b0, 1'b1, 3'h3, 1'b1, 3'h2});
    `CHK({BURST_LEN8, BURST_LEN_VALID, BURST_INTERLEAVE}, 3'h3)
    `CHK({CAS_LATENCY, TEST_MODE}, 4'h7)
    `CHK({WRITE_RECOVERY, WRITE_AUTOPRE_OK}, 5'h00)
    `CHK(pulse_cnt, 1)
  endtask : t_main

  // Lowered CKE and each pattern with one pin high must leave the word alone
  task automatic t_refused();
    logic [3:0] pins [4] = '{4'h8, 4'h4, 4'h2, 4'h1};
    wr(smr_pkg::SEL_MAIN, {1'b0, 3'h7, 1'b0, 1'b0, 3'h4, 1'b0, 3'h1});
    `CHK({WRITE_RECOVERY, BURST_LEN_VALID}, 5'h10)
    ctrl.set_cke(1'b0);
    ctrl.issue(smr_pkg::SEL_MAIN, 13'h1fff, 4'h0);
    ctrl.idle_bus();
    ctrl.set_cke(1'b1);
    foreach (pins[k]) begin
      ctrl.issue(smr_pkg::SEL_MAIN, 13'h1fff, pins[k]);
      ctrl.idle_bus();
    end
    @(posedge CLOCK);
    #1;
    `CHK(OPERATING_MODE, 13'h0e41)
  endtask : t_refused

  task automatic t_ext1();
    logic [7:0] ohm [4] = '{8'h00, 8'h4b, 8'h96, 8'h32};
    logic [2:0] c;
    logic [3:0] e;
    logic [12:0] v;
    for (int i = 0; i < 8; i++) begin
      c = 3'(i);
      v = {2'h0, c[0], c, c[1], c, c[0], c[1], 1'b0};
      e = (c == 3'h1) ? 4'h8 : (c == 3'h2) ? 4'h4 :
          (c == 3'h4) ? 4'h2 : (c == 3'h7) ? 4'h1 : 4'h0;
      wr(smr_pkg::SEL_EXT_ONE, v);
      `CHK(EXT_MODE_ONE, v)
      `CHK({CAL_DRIVE_HIGH, CAL_DRIVE_LOW, CAL_ADJUST_MODE,
            CAL_DEFAULT_STATE}, e)
      `CHK(ODT_OHMS, ohm[c[1:0]])
      `CHK({ADDITIVE_LATENCY, REDUCED_DRIVE, DLL_ON}, {c, c[1], 1'b1})
      `CHK(STROBE_COMPL_DISABLE, c[0])
      wr(smr_pkg::SEL_EXT_ONE, v & 13'h1c7f);
      `CHK({CAL_DRIVE_HIGH, CAL_DRIVE_LOW, CAL_ADJUST_MODE,
            CAL_DEFAULT_STATE}, 4'h0)
      `CHK(ADDITIVE_LATENCY, c)
    end
    `CHK(MODE_VALID[1], 1'b1)
  endtask : t_ext1

  // Lock wait spans exactly 200 cycles after the enabling edge
  task automatic dll_wait();
    repeat (198) @(posedge CLOCK);
    #1;
    `CHK(DLL_READY, 1'b0)
    @(posedge CLOCK);
    #1;
    `CHK(DLL_READY, 1'b1)
  endtask : dll_wait

  task automatic t_dll();
    wr(smr_pkg::SEL_EXT_ONE, 13'h0000);
    dll_wait();
    wr(smr_pkg::SEL_EXT_ONE, 13'h0001);
    `CHK({DLL_ON, DLL_READY}, 2'h0)
    @(posedge CLOCK);
    SELF_REFRESH_EXIT <= 1'b1;
    @(posedge CLOCK);
    SELF_REFRESH_EXIT <= 1'b0;
    @(posedge CLOCK);
    #1;
    `CHK(DLL_ON, 1'b1)
    dll_wait();
  endtask : t_dll

  task automatic t_ext2();
    logic [3:0] keep [8] = '{4'hf, 4'h3, 4'h1, 4'hf, 4'he, 4'hc, 4'h8, 4'hf};
    logic [2:0] c;
    for (int i = 0; i < 8; i++) begin
      c = 3'(i);
      wr(smr_pkg::SEL_EXT_TWO, {5'h00, c[0], 3'h0, c[1], c});
      `CHK(PARTIAL_ARRAY_SELF_REFRESH, c)
      `CHK(SELF_REFRESH_KEEP_BANKS, keep[i])
      `CHK({HIGH_TEMP_SELF_REFRESH, DUTY_CYCLE_CORRECTOR_EN},
           {c[0], c[1]})
    end
    ctrl.issue(smr_pkg::SEL_EXT_TWO, 13'h0080, 4'h0);
    ctrl.issue(smr_pkg::SEL_EXT_THREE, 13'h0000, 4'h0);
    ctrl.idle_bus();
    @(posedge CLOCK);
    #1;
    `CHK(EXT_MODE_TWO, 13'h0080)
    `CHK({EXT_MODE_THREE, MODE_VALID}, {13'h0000, 4'hf})
  endtask : t_ext2

  task automatic run_burst(input logic [2:0] s, input logic len8,
                           input logic il);
    logic [2:0] b;
    logic [2:0] e;
    int n;
    n = len8 ? 8 : 4;
    @(posedge CLOCK);
    BURST_START <= 1'b1;
    BURST_START_COL <= s;
    @(posedge CLOCK);
    BURST_START <= 1'b0;
    #1;
    for (int i = 0; i < n; i++) begin
      b = 3'(i);
      e = il ? (s ^ b) : {len8 ? s[2] ^ b[2] : s[2], s[1:0] + b[1:0]};
      `CHK(BURST_COL, e)
      `CHK({BURST_VALID, BURST_LAST}, {1'b1, i == n - 1})
      @(posedge CLOCK);
      #1;
    end
    `CHK(BURST_VALID, 1'b0)
  endtask : run_burst

  task automatic t_burst();
    logic [1:0] m;
    for (int i = 0; i < 4; i++) begin
      m = 2'(i);
      wr(smr_pkg::SEL_MAIN, {9'h000, m[0], m[1] ? 3'h3 : 3'h2});
      `CHK({BURST_LEN8, BURST_INTERLEAVE}, {m[1], m[0]})
      run_burst(3'h5, m[1], m[0]);
      run_burst(3'h6, m[1], m[0]);
    end
  endtask : t_burst

  initial begin
    repeat (5000) @(posedge CLOCK);
    n_fail++;
    give_verdict();
  end

  initial begin
    SRST = 1'b1;
    SELF_REFRESH_EXIT = 1'b0;
    BURST_START = 1'b0;
    BURST_START_COL = 3'h0;
    repeat (5) @(posedge CLOCK);
    SRST <= 1'b0;
    ctrl.set_cke(1'b1);
    #1;
    chk_clear();
    t_main();
    t_refused();
    t_ext1();
    t_dll();
    t_ext2();
    t_burst();
    @(posedge CLOCK);
    SRST <= 1'b1;
    @(posedge CLOCK);
    SRST <= 1'b0;
    @(posedge CLOCK);
    #1;
    chk_clear();
    give_verdict();
  end
endmodule : tb
